/* File: alu_pkg.sv */
// constants and types for the fractional data alu
package alu_pkg;

  localparam int unsigned WORD_W  = 24;
  localparam int unsigned LONG_W  = 48;
  localparam int unsigned EXT_W   = 8;
  localparam int unsigned ACC_W   = 56;

  localparam logic [WORD_W-1:0] WORD_MAX_POS = 24'h7FFFFF;
  localparam logic [WORD_W-1:0] WORD_MAX_NEG = 24'h800000;
  localparam logic [WORD_W-1:0] WORD_ONES    = 24'hFFFFFF;
  localparam logic [WORD_W-1:0] WORD_ZERO    = 24'h000000;
  localparam logic [ACC_W-1:0]  ACC_RESET    = 56'h00000000000000;
  localparam logic [WORD_W-1:0] REG_RESET    = 24'h000000;
  localparam logic              FLAG_RESET   = 1'b0;

  // scaling mode field of the status register
  typedef enum logic [1:0]
  {
    SCALE_NONE  = 2'h0,
    SCALE_DOWN  = 2'h1,
    SCALE_UP    = 2'h2
  } scale_mode_t;

  // one-hot operation codes
  typedef enum logic [11:0]
  {
    OP_NOP  = 12'h001,
    OP_MPY  = 12'h002,
    OP_MAC  = 12'h004,
    OP_ADD  = 12'h008,
    OP_SUB  = 12'h010,
    OP_DIV  = 12'h020,
    OP_NORM = 12'h040,
    OP_ASL  = 12'h080,
    OP_ASR  = 12'h100,
    OP_AND  = 12'h200,
    OP_OR   = 12'h400,
    OP_EOR  = 12'h800
  } alu_op_t;

  // input register selects: x0 x1 y0 y1
  localparam logic [1:0] SEL_X0 = 2'h0;
  localparam logic [1:0] SEL_X1 = 2'h1;
  localparam logic [1:0] SEL_Y0 = 2'h2;
  localparam logic [1:0] SEL_Y1 = 2'h3;

endpackage

/* File: shift_limit.sv */
// one output shifter and limiter for a data bus path
`timescale 1ns/1ps
`default_nettype none
module shift_limit
  import alu_pkg::*;
(
  input  wire logic [ACC_W-1:0]  acc_i,     // accumulator source
  input  wire scale_mode_t       mode_i,    // scaling mode bits
  output logic [ACC_W-1:0]       scaled_o,  // value after shifter
  output logic                   ovf_o,     // extension in use
  output logic                   neg_o      // sign of scaled value
);

  logic [ACC_W-1:0] up_val;
  logic [ACC_W-1:0] down_val;
  logic [EXT_W:0]   top_bits;

  assign up_val   = {acc_i[ACC_W-2:0], 1'b0};
  assign down_val = {acc_i[ACC_W-1], acc_i[ACC_W-1:1]};

  assign scaled_o = (mode_i == SCALE_UP)   ? up_val :
                    (mode_i == SCALE_DOWN) ? down_val : acc_i;

  assign top_bits = scaled_o[ACC_W-1:LONG_W-1];
  assign ovf_o    = ~((&top_bits) | ~(|top_bits));
  assign neg_o    = scaled_o[ACC_W-1];

endmodule
`default_nettype wire

/* File: data_alu.sv */
// fractional data alu with two output shifter limiters
//
// What this block does
// - four 24-bit inputs, two 48-bit accumulators with 8-bit extensions.
// - all arithmetic is signed fractional two's complement.
// - multiply-accumulate finishes in one cycle, no pipeline.
// - every listed operation finishes within one cycle.
// - sources are 24, 48 or 56 bits from own registers only.
// - every operation result lands in one of the two accumulators; a bus write to that accumulator in the same cycle wins.
// - accumulators read, and all registers written, over both buses as 24 or 48 bits.
// - both buses join into one 48-bit bus for long words.
// - two independent shifter limiters, one per bus.
// - shifter scales left, right or none per scaling mode bits.
// - each shifter gives a 24-bit result and overflow indication.
// - saturation is judged after the scaling shift.
// - values that fit pass through the limiter unchanged.
// - positive overflow gives 7FFFFF, or 7FFFFF FFFFFF for long reads.
// - negative overflow gives 800000, or 800000 000000 for long reads.
// - long reads limit all 48 bits by the x path limiter alone.
// - limiting changes only the bus value, never the accumulator.
// - limiting sets a sticky limit flag until cleared.
`timescale 1ns/1ps
`default_nettype none
module data_alu
  import alu_pkg::*;
(
  input  wire logic               clock_i,        // core clock
  input  wire logic               rst_b_i,        // sync reset, active low
  input  wire alu_op_t            op_i,           // operation this cycle
  input  wire logic               dst_b_i,        // destination acc b
  input  wire logic               src_acc_b_i,    // acc b, else acc a, as 56-bit source
  input  wire logic               src_is_acc_i,   // add/sub take 56-bit acc source
  input  wire logic               src_long_i,     // add/sub take 48-bit x or y pair
  input  wire logic [1:0]         src1_sel_i,     // multiplier first operand
  input  wire logic [1:0]         src2_sel_i,     // multiplier second operand
  input  wire logic               negate_i,       // negative accumulation
  input  wire logic               round_i,        // convergent rounding
  input  wire scale_mode_t        scale_mode_i,   // scaling mode bits
  input  wire logic               x_wr_i,         // write from x bus
  input  wire logic [2:0]         x_wr_dst_i,     // 0-3 input regs, 4 a, 5 b
  input  wire logic [WORD_W-1:0]  x_side_data_bus_i, // x bus write data
  input  wire logic               y_wr_i,         // write from y bus
  input  wire logic [2:0]         y_wr_dst_i,     // 0-3 input regs, 4 a, 5 b
  input  wire logic [WORD_W-1:0]  y_side_data_bus_i, // y bus write data
  input  wire logic               long_wr_i,      // long write over both buses
  input  wire logic [1:0]         long_wr_dst_i,  // 0 x pair, 1 y pair, 2 a, 3 b
  input  wire logic               x_rd_b_i,       // x bus reads acc b
  input  wire logic               y_rd_b_i,       // y bus reads acc b
  input  wire logic               long_rd_i,      // long read across both buses
  input  wire logic               limit_clr_i,    // clear the limit flag
  output logic [WORD_W-1:0]       x_side_data_bus_o, // x bus read data
  output logic [WORD_W-1:0]       y_side_data_bus_o, // y bus read data
  output logic                    x_ovf_o,        // x shifter overflow
  output logic                    y_ovf_o,        // y shifter overflow
  output logic                    limit_flag_o,   // sticky limit flag
  output logic [ACC_W-1:0]        acc_a_o,        // accumulator a
  output logic [ACC_W-1:0]        acc_b_o         // accumulator b
);

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [WORD_W-1:0] pick_in(input logic [1:0] sel,
                                                 input logic [WORD_W-1:0] a0,
                                                 input logic [WORD_W-1:0] a1,
                                                 input logic [WORD_W-1:0] b0,
                                                 input logic [WORD_W-1:0] b1);
    case (sel)
      SEL_X0:  pick_in = a0;
      SEL_X1:  pick_in = a1;
      SEL_Y0:  pick_in = b0;
      default: pick_in = b1;
    endcase
  endfunction

  function automatic logic [ACC_W-1:0] word_to_acc(input logic [WORD_W-1:0] w);
    word_to_acc = {{EXT_W{w[WORD_W-1]}}, w, WORD_ZERO};
  endfunction

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  // input and accumulator storage
  logic [WORD_W-1:0] in_q [4];
  logic [WORD_W-1:0] in_d [4];
  logic [ACC_W-1:0]  acc_a_q;
  logic [ACC_W-1:0]  acc_a_d;
  logic [ACC_W-1:0]  acc_b_q;
  logic [ACC_W-1:0]  acc_b_d;
  logic              limit_q;
  logic              limit_d;
  logic [WORD_W-1:0] x_out_q;
  logic [WORD_W-1:0] y_out_q;
  logic              x_ovf_q;
  logic              y_ovf_q;

  // ------------------------------------------------------------
  // multiply-accumulate
  // ------------------------------------------------------------
  logic [WORD_W-1:0] mul_a;
  logic [WORD_W-1:0] mul_b;
  logic [LONG_W-1:0] raw_prod;
  logic [ACC_W-1:0]  prod;
  logic [ACC_W-1:0]  dst_acc;
  logic [ACC_W-1:0]  oth_acc;
  logic [ACC_W-1:0]  mac_sum;
  logic [ACC_W-1:0]  pre_rnd;
  logic [ACC_W-1:0]  rnd_add;
  logic [ACC_W-1:0]  rnd_val;
  logic              rnd_tie;

  assign mul_a   = pick_in(src1_sel_i, in_q[0], in_q[1], in_q[2], in_q[3]);
  assign mul_b   = pick_in(src2_sel_i, in_q[0], in_q[1], in_q[2], in_q[3]);
  assign dst_acc = dst_b_i ? acc_b_q : acc_a_q;
  assign oth_acc = src_acc_b_i ? acc_b_q : acc_a_q;

  // signed fractional product, shifted left once to drop double sign
  assign raw_prod = LONG_W'($signed(mul_a) * $signed(mul_b));
  assign prod     = {{(EXT_W-1){raw_prod[LONG_W-1]}}, raw_prod, 1'b0};

  assign mac_sum = (op_i == OP_MAC) ? (negate_i ? dst_acc - prod : dst_acc + prod)
                                    : (negate_i ? ACC_W'(0) - prod : prod);
  assign pre_rnd = mac_sum;

  // round half to even at bit 24
  assign rnd_add = pre_rnd + {32'h0, 1'b1, 23'h0};
  assign rnd_tie = (pre_rnd[WORD_W-1:0] == WORD_MAX_NEG);
  assign rnd_val = {rnd_add[ACC_W-1:WORD_W+1],
                    rnd_add[WORD_W] & ~rnd_tie, WORD_ZERO};

  // ------------------------------------------------------------
  // arithmetic and logic
  // ------------------------------------------------------------
  logic [ACC_W-1:0]  add_src;
  logic [ACC_W-1:0]  div_src;
  logic [ACC_W-1:0]  div_shl;
  logic [ACC_W-1:0]  div_res;
  logic [ACC_W-1:0]  norm_res;
  logic [WORD_W-1:0] log_res;
  logic              norm_keep;
  logic [ACC_W-1:0]  op_res;

  // operand from own registers at 24, 48 or 56 bits
  assign add_src = src_is_acc_i ? oth_acc :
                   src_long_i   ? {{EXT_W{in_q[{src1_sel_i[1], 1'b1}][WORD_W-1]}},
                                   in_q[{src1_sel_i[1], 1'b1}],
                                   in_q[{src1_sel_i[1], 1'b0}]} :
                   word_to_acc(mul_a);

  // one nonrestoring divide step on the destination
  assign div_src = word_to_acc(mul_a);
  assign div_shl = {dst_acc[ACC_W-2:0], 1'b0};
  assign div_res = (dst_acc[ACC_W-1] ^ mul_a[WORD_W-1]) ? div_shl + div_src
                                                        : div_shl - div_src;

  // one normalisation step: shift left while bits 47 and 46 match
  assign norm_keep = (dst_acc[LONG_W-1] != dst_acc[LONG_W-2]);
  assign norm_res  = norm_keep ? dst_acc : {dst_acc[ACC_W-2:0], 1'b0};

  assign log_res = (op_i == OP_AND) ? dst_acc[LONG_W-1:WORD_W] & mul_a :
                   (op_i == OP_OR)  ? dst_acc[LONG_W-1:WORD_W] | mul_a :
                                      dst_acc[LONG_W-1:WORD_W] ^ mul_a;

  // all results formed within the cycle
  always_comb
  begin
    case (op_i)
      OP_MPY,
      OP_MAC:  op_res = round_i ? rnd_val : pre_rnd;
      OP_ADD:  op_res = dst_acc + add_src;
      OP_SUB:  op_res = dst_acc - add_src;
      OP_DIV:  op_res = {div_res[ACC_W-1:1], ~(dst_acc[ACC_W-1] ^ mul_a[WORD_W-1])};
      OP_NORM: op_res = norm_res;
      OP_ASL:  op_res = {dst_acc[ACC_W-2:0], 1'b0};
      OP_ASR:  op_res = {dst_acc[ACC_W-1], dst_acc[ACC_W-1:1]};
      OP_AND,
      OP_OR,
      OP_EOR:  op_res = {dst_acc[ACC_W-1:LONG_W], log_res, dst_acc[WORD_W-1:0]};
      default: op_res = dst_acc;
    endcase
  end

  logic op_active;
  assign op_active = (op_i != OP_NOP);

  // ------------------------------------------------------------
  // bus writes and accumulator update
  // ------------------------------------------------------------
  logic [LONG_W-1:0] long_bus;
  // joined 48-bit bus, x high half
  assign long_bus = {x_side_data_bus_i, y_side_data_bus_i};

  always_comb
  begin
    in_d[0] = in_q[0];
    in_d[1] = in_q[1];
    in_d[2] = in_q[2];
    in_d[3] = in_q[3];
    acc_a_d = acc_a_q;
    acc_b_d = acc_b_q;
    if (op_active && !dst_b_i)
      acc_a_d = op_res;
    if (op_active && dst_b_i)
      acc_b_d = op_res;
    if (x_wr_i && x_wr_dst_i < 3'h4)
      in_d[x_wr_dst_i[1:0]] = x_side_data_bus_i;
    if (x_wr_i && x_wr_dst_i == 3'h4)
      acc_a_d = word_to_acc(x_side_data_bus_i);
    if (x_wr_i && x_wr_dst_i == 3'h5)
      acc_b_d = word_to_acc(x_side_data_bus_i);
    if (y_wr_i && y_wr_dst_i < 3'h4)
      in_d[y_wr_dst_i[1:0]] = y_side_data_bus_i;
    if (y_wr_i && y_wr_dst_i == 3'h4)
      acc_a_d = word_to_acc(y_side_data_bus_i);
    if (y_wr_i && y_wr_dst_i == 3'h5)
      acc_b_d = word_to_acc(y_side_data_bus_i);
    if (long_wr_i)
    begin
      case (long_wr_dst_i)
        2'h0:
        begin
          in_d[1] = x_side_data_bus_i;
          in_d[0] = y_side_data_bus_i;
        end
        2'h1:
        begin
          in_d[3] = x_side_data_bus_i;
          in_d[2] = y_side_data_bus_i;
        end
        2'h2:    acc_a_d = {{EXT_W{long_bus[LONG_W-1]}}, long_bus};
        default: acc_b_d = {{EXT_W{long_bus[LONG_W-1]}}, long_bus};
      endcase
    end
  end

  // ------------------------------------------------------------
  // output shifter limiters
  // ------------------------------------------------------------
  logic [ACC_W-1:0] x_scaled;
  logic [ACC_W-1:0] y_scaled;
  logic             x_ext;
  logic             y_ext;
  logic             x_neg;
  logic             y_neg;

  shift_limit u_x_path
  (
    .acc_i    (x_rd_b_i ? acc_b_q : acc_a_q),
    .mode_i   (scale_mode_i),
    .scaled_o (x_scaled),
    .ovf_o    (x_ext),
    .neg_o    (x_neg)
  );

  shift_limit u_y_path
  (
    .acc_i    (y_rd_b_i ? acc_b_q : acc_a_q),
    .mode_i   (scale_mode_i),
    .scaled_o (y_scaled),
    .ovf_o    (y_ext),
    .neg_o    (y_neg)
  );

  logic [WORD_W-1:0] x_word;
  logic [WORD_W-1:0] y_word;
  logic [LONG_W-1:0] long_word;
  logic [WORD_W-1:0] x_bus_d;
  logic [WORD_W-1:0] y_bus_d;
  logic              x_lim;
  logic              y_lim;

  assign x_word = !x_ext ? x_scaled[LONG_W-1:WORD_W] :
                  x_neg  ? WORD_MAX_NEG : WORD_MAX_POS;
  assign y_word = !y_ext ? y_scaled[LONG_W-1:WORD_W] :
                  y_neg  ? WORD_MAX_NEG : WORD_MAX_POS;

  // x path drives the joint 48-bit limit decision
  assign long_word = !x_ext ? x_scaled[LONG_W-1:0] :
                     x_neg  ? {WORD_MAX_NEG, WORD_ZERO} : {WORD_MAX_POS, WORD_ONES};

  assign x_bus_d = long_rd_i ? long_word[LONG_W-1:WORD_W] : x_word;
  assign y_bus_d = long_rd_i ? long_word[WORD_W-1:0]      : y_word;
  // no read strobe: each path limits and flags whatever it selects, except the y path during long reads,
  // so software must pick a fitting source when no read is wanted
  assign x_lim   = x_ext;
  assign y_lim   = y_ext & ~long_rd_i;

  // sticky flag, a new limit beats a clear
  assign limit_d = (x_lim | y_lim) ? 1'b1 : (limit_clr_i ? 1'b0 : limit_q);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
    begin
      in_q[0] <= REG_RESET;
      in_q[1] <= REG_RESET;
      in_q[2] <= REG_RESET;
      in_q[3] <= REG_RESET;
      acc_a_q <= ACC_RESET;
      acc_b_q <= ACC_RESET;
      limit_q <= FLAG_RESET;
      x_out_q <= REG_RESET;
      y_out_q <= REG_RESET;
      x_ovf_q <= FLAG_RESET;
      y_ovf_q <= FLAG_RESET;
    end
    else
    begin
      in_q    <= in_d;
      // accumulators never take the limited value
      acc_a_q <= acc_a_d;
      acc_b_q <= acc_b_d;
      limit_q <= limit_d;
      x_out_q <= x_bus_d;
      y_out_q <= y_bus_d;
      x_ovf_q <= x_lim;
      y_ovf_q <= y_lim;
    end
  end

  assign x_side_data_bus_o = x_out_q;
  assign y_side_data_bus_o = y_out_q;
  assign x_ovf_o           = x_ovf_q;
  assign y_ovf_o           = y_ovf_q;
  assign limit_flag_o      = limit_q;
  assign acc_a_o           = acc_a_q;
  assign acc_b_o           = acc_b_q;

endmodule
`default_nettype wire

/* File: data_alu_checker.sv */
// concurrent checks on the data alu ports
`timescale 1ns/1ps
`default_nettype none
module data_alu_checker
  import alu_pkg::*;
(
  input wire logic              clock_i,           // clock
  input wire logic              rst_b_i,           // reset
  input wire alu_op_t           op_i,              // operation
  input wire scale_mode_t       scale_mode_i,      // scaling
  input wire logic              x_wr_i,            // x write
  input wire logic              y_wr_i,            // y write
  input wire logic              long_wr_i,         // long write
  input wire logic              x_rd_b_i,          // x reads b
  input wire logic              y_rd_b_i,          // y reads b
  input wire logic              long_rd_i,         // long read
  input wire logic              limit_clr_i,       // flag clear
  input wire logic [WORD_W-1:0] x_side_data_bus_o, // x read data
  input wire logic [WORD_W-1:0] y_side_data_bus_o, // y read data
  input wire logic              x_ovf_o,           // x overflow
  input wire logic              limit_flag_o,      // sticky flag
  input wire logic [ACC_W-1:0]  acc_a_o,           // acc a
  input wire logic [ACC_W-1:0]  acc_b_o            // acc b
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);

  // ----------------------------------------
  // limiter decisions, limit flag and idle accumulator hold
  // ----------------------------------------
  // extension unused when bits 55..47 agree
  wire logic [ACC_W-1:0] x_src  = x_rd_b_i ? acc_b_o : acc_a_o;
  wire logic             x_fits = (x_src[55:47] == 9'h000) || (x_src[55:47] == 9'h1FF);
  wire logic             b_fits = (acc_b_o[55:47] == 9'h000) || (acc_b_o[55:47] == 9'h1FF);

  sequence s_read_x;
    scale_mode_i == SCALE_NONE;
  endsequence

  AST_PASS: assert property (
    s_read_x ##0 x_fits |=> x_side_data_bus_o == $past(x_src[47:24]) && !x_ovf_o)
    else $error("fitting value altered on x bus");
  AST_POS: assert property (
    s_read_x ##0 (!x_src[55] && !x_fits) |=> x_side_data_bus_o == WORD_MAX_POS && x_ovf_o)
    else $error("positive overflow not limited");
  AST_NEG: assert property (
    s_read_x ##0 (x_src[55] && !x_fits) |=> x_side_data_bus_o == WORD_MAX_NEG && x_ovf_o)
    else $error("negative overflow not limited");
  AST_LONG: assert property (
    s_read_x ##0 (long_rd_i && !x_fits)
    |=> y_side_data_bus_o == ($past(x_src[55]) ? WORD_ZERO : WORD_ONES))
    else $error("long read low word not limited");
  AST_DOWN: assert property (
    !x_rd_b_i && scale_mode_i == SCALE_DOWN && (acc_a_o[55:48] == 8'h00 || acc_a_o[55:48] == 8'hFF)
    |=> x_side_data_bus_o == $past(acc_a_o[48:25]))
    else $error("right scaling wrong");
  AST_UP: assert property (
    !x_rd_b_i && scale_mode_i == SCALE_UP && (acc_a_o[55:46] == 10'h000 || acc_a_o[55:46] == 10'h3FF)
    |=> x_side_data_bus_o == $past(acc_a_o[46:23]))
    else $error("left scaling wrong");
  AST_YPATH: assert property (
    y_rd_b_i && !long_rd_i && scale_mode_i == SCALE_NONE && b_fits
    |=> y_side_data_bus_o == $past(acc_b_o[47:24]))
    else $error("y path does not follow acc b");
  AST_FLAG_SET: assert property (x_ovf_o |-> limit_flag_o)
    else $error("limiting without flag");
  AST_STICKY: assert property (limit_flag_o && !limit_clr_i |=> limit_flag_o)
    else $error("flag dropped without clear");
  AST_HOLD: assert property (
    op_i == OP_NOP && !x_wr_i && !y_wr_i && !long_wr_i |=> $stable(acc_a_o) && $stable(acc_b_o))
    else $error("accumulator changed while idle");
endmodule

bind data_alu data_alu_checker i_data_alu_checker (
  .clock_i, .rst_b_i, .op_i, .scale_mode_i, .x_wr_i, .y_wr_i, .long_wr_i, .x_rd_b_i,
  .y_rd_b_i, .long_rd_i, .limit_clr_i, .x_side_data_bus_o, .y_side_data_bus_o, .x_ovf_o,
  .limit_flag_o, .acc_a_o, .acc_b_o
);
`default_nettype wire

/* File: data_mem_model.sv */
// data memory port model driving one data bus into the alu
`timescale 1ns/1ps
`default_nettype none
module data_mem_model
  import alu_pkg::*;
(
  input  wire logic [0:0]        clock_i, // core clock
  input  wire logic              offer_i, // memory drives bus
  input  wire logic [WORD_W-1:0] word_i,  // word to send
  output logic [WORD_W-1:0]      bus_o    // bus into the alu
);
  logic [WORD_W-1:0] last_q = 24'h000000;
  // word or half-long
  // released bus shows inverse, never a stale copy
  assign bus_o = offer_i ? word_i : ~last_q;
  always_ff @(posedge clock_i)
  begin
    if (offer_i)
      last_q <= word_i;
  end
endmodule
`default_nettype wire

/* File: tb_dsp_data_alu_shift_limit.sv */
// self-checking bench for the data alu shift limit block
`timescale 1ns/1ps
`default_nettype none
module tb_dsp_data_alu_shift_limit
  import alu_pkg::*;
;
  logic              clock_i = 1'b0;
  logic              rst_b_i, dst_b_i, src_acc_b_i, src_is_acc_i, src_long_i, negate_i;
  logic              round_i, x_wr_i, y_wr_i, long_wr_i, x_rd_b_i, y_rd_b_i, long_rd_i;
  logic              limit_clr_i, x_offer, y_offer, x_ovf_o, y_ovf_o, limit_flag_o;
  logic [1:0]        src1_sel_i, src2_sel_i, long_wr_dst_i;
  logic [2:0]        x_wr_dst_i, y_wr_dst_i;
  logic [WORD_W-1:0] x_word, y_word, x_side_data_bus_i, y_side_data_bus_i;
  logic [WORD_W-1:0] x_side_data_bus_o, y_side_data_bus_o;
  logic [ACC_W-1:0]  acc_a_o, acc_b_o;
  alu_op_t           op_i;
  scale_mode_t       scale_mode_i;
  int                n_errors = 0;
  int                n_checks = 0;

  always #2.5 clock_i = ~clock_i;

  data_alu i_data_alu (
    .clock_i, .rst_b_i, .op_i, .dst_b_i, .src_acc_b_i, .src_is_acc_i, .src_long_i,
    .src1_sel_i, .src2_sel_i, .negate_i, .round_i, .scale_mode_i, .x_wr_i, .x_wr_dst_i,
    .x_side_data_bus_i, .y_wr_i, .y_wr_dst_i, .y_side_data_bus_i, .long_wr_i,
    .long_wr_dst_i, .x_rd_b_i, .y_rd_b_i, .long_rd_i, .limit_clr_i, .x_side_data_bus_o,
    .y_side_data_bus_o, .x_ovf_o, .y_ovf_o, .limit_flag_o, .acc_a_o, .acc_b_o
  );
  data_mem_model i_data_mem_model_x (.clock_i, .offer_i(x_offer), .word_i(x_word),
    .bus_o(x_side_data_bus_i));
  data_mem_model i_data_mem_model_y (.clock_i, .offer_i(y_offer), .word_i(y_word),
    .bus_o(y_side_data_bus_i));

  // ----------------------------------------
  // compare and drive helpers
  // ----------------------------------------
  task automatic tally(input logic ok, input string what);
    n_checks++;
    if (ok !== 1'b1)
    begin
      n_errors++;
      $display("[ERR] %0t %s mismatch", $time, what);
    end
  endtask
  task automatic chk_acc(input logic [ACC_W-1:0] got, exp);
    tally(got === exp, "accumulator");
  endtask
  task automatic chk_word(input logic [WORD_W-1:0] got, exp);
    tally(got === exp, "bus word");
  endtask
  task automatic chk_bit(input logic got, exp);
    tally(got === exp, "flag");
  endtask
  task automatic idle;
    op_i <= OP_NOP;
    x_wr_i <= 1'b0;
    y_wr_i <= 1'b0;
    long_wr_i <= 1'b0;
    x_offer <= 1'b0;
    y_offer <= 1'b0;
    x_rd_b_i <= 1'b0;
    y_rd_b_i <= 1'b0;
    long_rd_i <= 1'b0;
    limit_clr_i <= 1'b0;
    src_long_i <= 1'b0;
    scale_mode_i <= SCALE_NONE;
  endtask
  // request stands for exactly one sampling edge
  task automatic fin;
    @(posedge clock_i);
    idle();
    #1;
  endtask
  task automatic set_op(input alu_op_t op, input logic [1:0] s1, s2, input logic n, r, a, b);
    op_i <= op;
    src1_sel_i <= s1;
    src2_sel_i <= s2;
    negate_i <= n;
    round_i <= r;
    src_is_acc_i <= a;
    dst_b_i <= b;
    src_acc_b_i <= b;
  endtask
  task automatic do_op(input alu_op_t op, input logic [1:0] s1, s2, input logic n, r, a, b);
    @(posedge clock_i);
    set_op(op, s1, s2, n, r, a, b);
    fin();
  endtask
  task automatic wr_word(input logic [2:0] dst, input logic [WORD_W-1:0] v);
    @(posedge clock_i);
    x_wr_i <= 1'b1;
    x_wr_dst_i <= dst;
    x_offer <= 1'b1;
    x_word <= v;
    fin();
  endtask
  task automatic wr_long(input logic [1:0] dst, input logic [LONG_W-1:0] v);
    @(posedge clock_i);
    long_wr_i <= 1'b1;
    long_wr_dst_i <= dst;
    x_offer <= 1'b1;
    y_offer <= 1'b1;
    x_word <= v[47:24];
    y_word <= v[23:0];
    fin();
  endtask
  task automatic rd(input logic xb, yb, lng, input scale_mode_t sc);
    @(posedge clock_i);
    x_rd_b_i <= xb;
    y_rd_b_i <= yb;
    long_rd_i <= lng;
    scale_mode_i <= sc;
    fin();
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_moves;
    wr_word(3'h0, 24'h400000);
    @(posedge clock_i);
    y_wr_i <= 1'b1;
    y_wr_dst_i <= 3'h2;
    y_offer <= 1'b1;
    y_word <= 24'h400000;
    fin();
    wr_word(3'h4, 24'h123456);
    chk_acc(acc_a_o, 56'h00123456000000);
    rd(1'b0, 1'b0, 1'b0, SCALE_NONE);
    chk_word(x_side_data_bus_o, 24'h123456);
    rd(1'b0, 1'b0, 1'b0, SCALE_UP);
    chk_word(x_side_data_bus_o, 24'h2468AC);
    wr_long(2'h3, 48'h876543210FED);
    chk_acc(acc_b_o, 56'hFF876543210FED);
  endtask
  task automatic t_mac;
    do_op(OP_MPY, SEL_X0, SEL_Y0, 1'b0, 1'b0, 1'b0, 1'b0);
    chk_acc(acc_a_o, 56'h00200000000000);
    do_op(OP_MAC, SEL_X0, SEL_Y0, 1'b1, 1'b0, 1'b0, 1'b0);
    chk_acc(acc_a_o, 56'h00000000000000);
    wr_word(3'h0, 24'hC00000);
    do_op(OP_MPY, SEL_X0, SEL_Y0, 1'b0, 1'b0, 1'b0, 1'b0);
    chk_acc(acc_a_o, 56'hFFE00000000000);
    wr_word(3'h0, 24'h000001);
    wr_word(3'h4, 24'h000000);
    do_op(OP_MAC, SEL_X0, SEL_Y0, 1'b0, 1'b1, 1'b0, 1'b0);
    chk_acc(acc_a_o, 56'h00000000000000);
    wr_word(3'h4, 24'h000001);
    do_op(OP_MAC, SEL_X0, SEL_Y0, 1'b0, 1'b1, 1'b0, 1'b0);
    chk_acc(acc_a_o, 56'h00000002000000);
  endtask
  task automatic t_ops;
    alu_op_t           ops[9] = '{OP_AND, OP_EOR, OP_ASL, OP_ASR, OP_NORM, OP_SUB, OP_OR,
                                  OP_ADD, OP_NOP};
    logic [WORD_W-1:0] ex[9] = '{24'h000F0F, 24'h00F0F0, 24'h01E1E0, 24'h00F0F0, 24'h01E1E0,
                                 24'h00E1E1, 24'h00FFFF, 24'h01FFFE, 24'h01FFFE};
    wr_word(3'h0, 24'h00FFFF);
    wr_word(3'h4, 24'h0F0F0F);
    foreach (ops[i])
    begin
      do_op(ops[i], SEL_X0, SEL_X0, 1'b0, 1'b0, 1'b0, 1'b0);
      chk_acc(acc_a_o, {8'h00, ex[i], 24'h000000});
    end
    chk_acc(acc_b_o, 56'hFF876543210FED);
  endtask
  task automatic t_limit;
    wr_long(2'h2, 48'h400000000000);
    do_op(OP_ADD, SEL_X0, SEL_X0, 1'b0, 1'b0, 1'b1, 1'b0);
    chk_acc(acc_a_o, 56'h00800000000000);
    rd(1'b0, 1'b0, 1'b0, SCALE_NONE);
    chk_word(x_side_data_bus_o, WORD_MAX_POS);
    chk_word(y_side_data_bus_o, WORD_MAX_POS);
    chk_bit(y_ovf_o, 1'b1);
    chk_bit(x_ovf_o, 1'b1);
    chk_bit(limit_flag_o, 1'b1);
    chk_acc(acc_a_o, 56'h00800000000000);
    rd(1'b0, 1'b0, 1'b1, SCALE_NONE);
    chk_word(y_side_data_bus_o, WORD_ONES);
    chk_bit(y_ovf_o, 1'b0);
    wr_long(2'h3, 48'h800000000000);
    do_op(OP_ADD, SEL_X0, SEL_X0, 1'b0, 1'b0, 1'b1, 1'b1);
    chk_acc(acc_b_o, 56'hFF000000000000);
    rd(1'b1, 1'b0, 1'b1, SCALE_NONE);
    chk_word(x_side_data_bus_o, WORD_MAX_NEG);
    chk_word(y_side_data_bus_o, WORD_ZERO);
    wr_word(3'h4, 24'h000000);
    @(posedge clock_i);
    limit_clr_i <= 1'b1;
    fin();
    chk_bit(limit_flag_o, 1'b0);
  endtask
  task automatic t_scale;
    wr_word(3'h4, 24'h400000);
    rd(1'b0, 1'b0, 1'b0, SCALE_UP);
    chk_word(x_side_data_bus_o, WORD_MAX_POS);
    rd(1'b0, 1'b0, 1'b0, SCALE_DOWN);
    chk_word(x_side_data_bus_o, 24'h200000);
    wr_long(2'h3, 48'h123456000000);
    rd(1'b0, 1'b1, 1'b0, SCALE_NONE);
    chk_word(y_side_data_bus_o, 24'h123456);
    chk_word(x_side_data_bus_o, 24'h400000);
  endtask
  task automatic t_div_long;
    @(posedge clock_i);
    set_op(OP_ADD, SEL_Y0, SEL_Y0, 1'b0, 1'b0, 1'b0, 1'b0);
    src_long_i <= 1'b1;
    fin();
    chk_acc(acc_a_o, 56'h00400000400000);
    wr_word(3'h4, 24'h100000);
    do_op(OP_DIV, SEL_Y0, SEL_Y0, 1'b0, 1'b0, 1'b0, 1'b0);
    chk_acc(acc_a_o, 56'hFFE00000000001);
    do_op(OP_DIV, SEL_Y0, SEL_Y0, 1'b0, 1'b0, 1'b0, 1'b0);
    chk_acc(acc_a_o, 56'h00000000000002);
  endtask

  task automatic end_of_test;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge clock_i);
    n_errors++;
    end_of_test();
  end

  initial
  begin
    rst_b_i <= 1'b0;
    x_wr_dst_i <= 3'h0;
    y_wr_dst_i <= 3'h0;
    long_wr_dst_i <= 2'h0;
    x_word <= 24'h000000;
    y_word <= 24'h000000;
    idle();
    set_op(OP_NOP, SEL_X0, SEL_Y0, 1'b0, 1'b0, 1'b0, 1'b0);
    repeat (20) @(posedge clock_i);
    rst_b_i <= 1'b1;
    #1;
    chk_acc(acc_a_o, ACC_RESET);
    chk_acc(acc_b_o, ACC_RESET);
    chk_bit(limit_flag_o, FLAG_RESET);
    t_moves();
    t_mac();
    t_ops();
    t_limit();
    t_scale();
    t_div_long();
    end_of_test();
  end
endmodule
`default_nettype wire
